// *** design/daf_defs.svh ***
`ifndef DAF_DEFS_SVH
`define DAF_DEFS_SVH

// ==========================================================
// Register map on the diagnostic serial target
`define DAF_SERIAL_ADDR 7'h51
`define DAF_PRIMARY_OFFSET 8'h70
`define DAF_RECEIVE_OFFSET 8'h71

// ==========================================================
// Reset values
`define DAF_PRIMARY_RESET 8'h00
`define DAF_RECEIVE_RESET 8'h00

// ==========================================================
// Field positions
`define DAF_TEMP_HIGH_BIT 7
`define DAF_TEMP_LOW_BIT 6
`define DAF_VOLT_HIGH_BIT 5
`define DAF_VOLT_LOW_BIT 4
`define DAF_BIAS_HIGH_BIT 3
`define DAF_BIAS_LOW_BIT 2
`define DAF_TXPWR_HIGH_BIT 1
`define DAF_TXPWR_LOW_BIT 0
`define DAF_RX_OVERLOAD_BIT 7
`define DAF_RX_LOSS_BIT 6
`define DAF_RECEIVE_RSVD_MASK 8'h3f

`endif

// *** design/daf_pkg.sv ***
`default_nettype none

package daf_pkg;

  // ==========================================================
  // Types
  typedef logic [7:0] daf_byte_t;

  typedef enum logic [2:0] {
    DAF_P_TEMP = 3'b000,
    DAF_P_VOLT = 3'b001,
    DAF_P_BIAS = 3'b010,
    DAF_P_TXPWR = 3'b011,
    DAF_P_RXPWR = 3'b100
  } daf_param_t;

  typedef enum logic [1:0] {
    DAF_SEL_NONE = 2'b00,
    DAF_SEL_PRIMARY = 2'b01,
    DAF_SEL_RECEIVE = 2'b10
  } daf_sel_t;

endpackage

`default_nettype wire

// *** design/daf_compare.sv ***
`timescale 1ns/10ps
`default_nettype none

module daf_compare
  import daf_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input wire logic [DATA_W-1:0] result_in,
  input wire logic [DATA_W-1:0] upper_in,
  input wire logic [DATA_W-1:0] lower_in,
  output logic above_out,
  output logic below_out
);

  // ==========================================================
  // Strict unsigned compare; equal to a limit is within limits
  always_comb begin
    above_out = (result_in > upper_in);
    below_out = (result_in < lower_in);
  end

endmodule

`default_nettype wire

// *** design/daf_top.sv ***
// Operation
// - Temperature above upper limit sets primary bit7
// - Temperature below lower limit sets primary bit6
// - Supply above upper limit sets primary bit5
// - Supply below lower limit sets primary bit4
// - Laser current above upper sets primary bit3
// - Laser current below lower sets primary bit2
// - Transmit power above upper sets primary bit1
// - Transmit power below lower sets primary bit0
// - Receive power above upper sets receive bit7
// - Receive power below lower sets receive bit6
// - Flag reads condition; host writes ignored
// - Both bytes zero at power-up
// - Bytes at 112, 113 on diagnostic target
`timescale 1ns/10ps
`default_nettype none
`include "daf_defs.svh"

module daf_top
  import daf_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int NUM_PARAMS = 5
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] temperature_result_hi_in,
  input wire logic [7:0] temp_alarm_upper_hi_in,
  input wire logic [7:0] temp_alarm_lower_hi_in,
  input wire logic temperature_store_in,
  input wire logic [7:0] supply_result_hi_in,
  input wire logic [7:0] supply_alarm_upper_hi_in,
  input wire logic [7:0] supply_alarm_lower_hi_in,
  input wire logic supply_store_in,
  input wire logic [7:0] laser_current_result_hi_in,
  input wire logic [7:0] laser_current_alarm_upper_hi_in,
  input wire logic [7:0] laser_current_alarm_lower_hi_in,
  input wire logic laser_current_store_in,
  input wire logic [7:0] transmit_power_result_hi_in,
  input wire logic [7:0] transmit_power_alarm_upper_hi_in,
  input wire logic [7:0] transmit_power_alarm_lower_hi_in,
  input wire logic transmit_power_store_in,
  input wire logic [7:0] receive_power_result_hi_in,
  input wire logic [7:0] receive_power_alarm_upper_hi_in,
  input wire logic [7:0] receive_power_alarm_lower_hi_in,
  input wire logic receive_power_store_in,
  input wire logic [6:0] reg_target_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rd_ack_out,
  output logic reg_wr_ack_out,
  output logic [7:0] alarm_flags_primary_out,
  output logic [7:0] alarm_flags_receive_out
);

  // ==========================================================
  // Elaboration checks
  // The two byte maps fix the layout; other sizes have no bit
  // positions to land in, so they are refused before simulation.
  generate
    if (DATA_W != 8) begin : g_bad_width
      $error("daf_top: only 8-bit high bytes are compared");
    end
    if (NUM_PARAMS != 5) begin : g_bad_count
      $error("daf_top: flag layout serves exactly five parameters");
    end
  endgenerate

  // ==========================================================
  // Reset release
  // Two flops so the release never lands close to a clock edge
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign rst_n = rst_sync_reg;

  // ==========================================================
  // Parameter gathering
  logic [DATA_W-1:0] result_arr [NUM_PARAMS];
  logic [DATA_W-1:0] upper_arr [NUM_PARAMS];
  logic [DATA_W-1:0] lower_arr [NUM_PARAMS];
  logic [NUM_PARAMS-1:0] store_vec;
  logic [NUM_PARAMS-1:0] above_vec;
  logic [NUM_PARAMS-1:0] below_vec;

  assign result_arr[DAF_P_TEMP] = temperature_result_hi_in;
  assign upper_arr[DAF_P_TEMP] = temp_alarm_upper_hi_in;
  assign lower_arr[DAF_P_TEMP] = temp_alarm_lower_hi_in;
  assign store_vec[DAF_P_TEMP] = temperature_store_in;
  assign result_arr[DAF_P_VOLT] = supply_result_hi_in;
  assign upper_arr[DAF_P_VOLT] = supply_alarm_upper_hi_in;
  assign lower_arr[DAF_P_VOLT] = supply_alarm_lower_hi_in;
  assign store_vec[DAF_P_VOLT] = supply_store_in;
  assign result_arr[DAF_P_BIAS] = laser_current_result_hi_in;
  assign upper_arr[DAF_P_BIAS] = laser_current_alarm_upper_hi_in;
  assign lower_arr[DAF_P_BIAS] = laser_current_alarm_lower_hi_in;
  assign store_vec[DAF_P_BIAS] = laser_current_store_in;
  assign result_arr[DAF_P_TXPWR] = transmit_power_result_hi_in;
  assign upper_arr[DAF_P_TXPWR] = transmit_power_alarm_upper_hi_in;
  assign lower_arr[DAF_P_TXPWR] = transmit_power_alarm_lower_hi_in;
  assign store_vec[DAF_P_TXPWR] = transmit_power_store_in;
  assign result_arr[DAF_P_RXPWR] = receive_power_result_hi_in;
  assign upper_arr[DAF_P_RXPWR] = receive_power_alarm_upper_hi_in;
  assign lower_arr[DAF_P_RXPWR] = receive_power_alarm_lower_hi_in;
  assign store_vec[DAF_P_RXPWR] = receive_power_store_in;

  // ==========================================================
  // Comparators, one per parameter
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PARAMS; gi++) begin : g_cmp
      daf_compare #(
        .DATA_W(DATA_W)
      ) u_cmp (
        .result_in(result_arr[gi]),
        .upper_in(upper_arr[gi]),
        .lower_in(lower_arr[gi]),
        .above_out(above_vec[gi]),
        .below_out(below_vec[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Flag state
  // Held between conversions so a threshold rewrite alone does not
  // move a flag; it takes effect at the next stored result.
  logic [NUM_PARAMS-1:0] high_flag_reg;
  logic [NUM_PARAMS-1:0] high_flag_next;
  logic [NUM_PARAMS-1:0] low_flag_reg;
  logic [NUM_PARAMS-1:0] low_flag_next;

  always_comb begin
    high_flag_next = high_flag_reg;
    low_flag_next = low_flag_reg;
    for (int i = 0; i < NUM_PARAMS; i++) begin
      if (store_vec[i]) begin
        high_flag_next[i] = above_vec[i];
        low_flag_next[i] = below_vec[i];
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      high_flag_reg <= '0;
      low_flag_reg <= '0;
    end else begin
      high_flag_reg <= high_flag_next;
      low_flag_reg <= low_flag_next;
    end
  end

  // ==========================================================
  // Byte assembly
  logic [7:0] primary_byte;
  logic [7:0] receive_byte;

  always_comb begin
    primary_byte = `DAF_PRIMARY_RESET;
    receive_byte = `DAF_RECEIVE_RESET;
    primary_byte[`DAF_TEMP_HIGH_BIT] = high_flag_reg[DAF_P_TEMP];
    primary_byte[`DAF_TEMP_LOW_BIT] = low_flag_reg[DAF_P_TEMP];
    primary_byte[`DAF_VOLT_HIGH_BIT] = high_flag_reg[DAF_P_VOLT];
    primary_byte[`DAF_VOLT_LOW_BIT] = low_flag_reg[DAF_P_VOLT];
    primary_byte[`DAF_BIAS_HIGH_BIT] = high_flag_reg[DAF_P_BIAS];
    primary_byte[`DAF_BIAS_LOW_BIT] = low_flag_reg[DAF_P_BIAS];
    primary_byte[`DAF_TXPWR_HIGH_BIT] = high_flag_reg[DAF_P_TXPWR];
    primary_byte[`DAF_TXPWR_LOW_BIT] = low_flag_reg[DAF_P_TXPWR];
    receive_byte[`DAF_RX_OVERLOAD_BIT] = high_flag_reg[DAF_P_RXPWR];
    receive_byte[`DAF_RX_LOSS_BIT] = low_flag_reg[DAF_P_RXPWR];
    receive_byte = receive_byte & ~`DAF_RECEIVE_RSVD_MASK;
  end

  // ==========================================================
  // Mirror outputs
  // Registered so the pins never show a half-assembled byte;
  // this costs one cycle of lag behind the flags.
  logic [7:0] primary_reg;
  logic [7:0] primary_next;
  logic [7:0] receive_reg;
  logic [7:0] receive_next;

  always_comb begin
    primary_next = primary_byte;
    receive_next = receive_byte;
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      primary_reg <= `DAF_PRIMARY_RESET;
      receive_reg <= `DAF_RECEIVE_RESET;
    end else begin
      primary_reg <= primary_next;
      receive_reg <= receive_next;
    end
  end

  // ==========================================================
  // Register port
  function automatic daf_sel_t decode_sel(input logic [6:0] target,
                                          input logic [7:0] addr);
    daf_sel_t sel;
    sel = DAF_SEL_NONE;
    if (target == `DAF_SERIAL_ADDR) begin
      if (addr == `DAF_PRIMARY_OFFSET) begin
        sel = DAF_SEL_PRIMARY;
      end else if (addr == `DAF_RECEIVE_OFFSET) begin
        sel = DAF_SEL_RECEIVE;
      end
    end
    return sel;
  endfunction

  daf_sel_t rd_sel;
  daf_sel_t wr_sel;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rd_ack_reg;
  logic rd_ack_next;
  logic wr_ack_reg;
  logic wr_ack_next;

  // Reads win over writes when both strobes arrive together
  assign rd_sel = decode_sel(reg_target_in, reg_addr_in);
  assign wr_sel = decode_sel(reg_target_in, reg_addr_in);

  // Reads see the flags as they stood before this cycle's store
  always_comb begin
    rdata_next = rdata_reg;
    rd_ack_next = 1'b0;
    wr_ack_next = 1'b0;
    if (reg_rd_in) begin
      unique case (rd_sel)
        DAF_SEL_PRIMARY: begin
          rdata_next = primary_byte;
          rd_ack_next = 1'b1;
        end
        DAF_SEL_RECEIVE: begin
          rdata_next = receive_byte;
          rd_ack_next = 1'b1;
        end
        DAF_SEL_NONE: begin
          rdata_next = rdata_reg;
        end
        default: begin
          rdata_next = rdata_reg;
        end
      endcase
    end else if (reg_wr_in) begin
      unique case (wr_sel)
        DAF_SEL_PRIMARY, DAF_SEL_RECEIVE: begin
          // Accepted and dropped; data never reaches the flags
          wr_ack_next = 1'b1;
        end
        DAF_SEL_NONE: begin
          wr_ack_next = 1'b0;
        end
        default: begin
          wr_ack_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
      rd_ack_reg <= 1'b0;
      wr_ack_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rd_ack_reg <= rd_ack_next;
      wr_ack_reg <= wr_ack_next;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign reg_rd_ack_out = rd_ack_reg;
  assign reg_wr_ack_out = wr_ack_reg;
  assign alarm_flags_primary_out = primary_reg;
  assign alarm_flags_receive_out = receive_reg;

endmodule

`default_nettype wire

// *** test/daf_top_sva.sv ***
`timescale 1ns/10ps
`default_nettype none

module daf_top_sva (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] temperature_result_hi_in,
  input wire logic [7:0] temp_alarm_upper_hi_in,
  input wire logic [7:0] temp_alarm_lower_hi_in,
  input wire logic temperature_store_in,
  input wire logic [7:0] receive_power_result_hi_in,
  input wire logic [7:0] receive_power_alarm_upper_hi_in,
  input wire logic [7:0] receive_power_alarm_lower_hi_in,
  input wire logic receive_power_store_in,
  input wire logic [6:0] reg_target_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rd_ack_out,
  input wire logic reg_wr_ack_out,
  input wire logic [7:0] alarm_flags_primary_out,
  input wire logic [7:0] alarm_flags_receive_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // ==========================================================
  // Helpers
  logic hit, wr_hit, t_hi, t_lo, r_hi, r_lo;
  assign hit = reg_target_in == 7'h51 && (reg_addr_in == 8'h70 || reg_addr_in == 8'h71);
  assign wr_hit = hit && reg_wr_in && !reg_rd_in;
  assign t_hi = temperature_result_hi_in > temp_alarm_upper_hi_in;
  assign t_lo = temperature_result_hi_in < temp_alarm_lower_hi_in;
  assign r_hi = receive_power_result_hi_in > receive_power_alarm_upper_hi_in;
  assign r_lo = receive_power_result_hi_in < receive_power_alarm_lower_hi_in;
  sequence s_rx_quiet;
    !receive_power_store_in ##1 !receive_power_store_in;
  endsequence
  // ==========================================================
  // Properties
  a_temp_high_flag: assert property (
    temperature_store_in |-> ##2 alarm_flags_primary_out[7] == $past(t_hi, 2))
    else $error("temperature high flag wrong");
  a_temp_low_flag: assert property (
    temperature_store_in |-> ##2 alarm_flags_primary_out[6] == $past(t_lo, 2))
    else $error("temperature low flag wrong");
  a_rx_over_flag: assert property (
    receive_power_store_in |-> ##2 alarm_flags_receive_out[7] == $past(r_hi, 2))
    else $error("receive overload flag wrong");
  a_rx_loss_flag: assert property (
    receive_power_store_in |-> ##2 alarm_flags_receive_out[6] == $past(r_lo, 2))
    else $error("receive loss flag wrong");
  a_rsvd_bits_zero: assert property (alarm_flags_receive_out[5:0] == 6'h00)
    else $error("receive reserved bits not zero");
  a_read_ack_hit: assert property (reg_rd_in |=> reg_rd_ack_out == $past(hit))
    else $error("read ack does not match decode");
  a_write_ack_hit: assert property (reg_wr_in |=> reg_wr_ack_out == $past(wr_hit))
    else $error("write ack does not match decode");
  a_rdata_only_ack: assert property ($changed(reg_rdata_out) |-> reg_rd_ack_out)
    else $error("read data moved without a hit read");
  a_rx_flag_hold: assert property (s_rx_quiet |=> $stable(alarm_flags_receive_out))
    else $error("receive flags moved without a store");
endmodule

bind daf_top daf_top_sva u_sva (.*);

`default_nettype wire

// *** test/daf_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module daf_host_model (
  input wire logic clk_in,
  output logic [6:0] tgt_out,
  output logic [7:0] addr_out,
  output logic rd_out,
  output logic wr_out,
  output logic [7:0] wd_out,
  input wire logic [7:0] rdata_in,
  input wire logic rack_in,
  input wire logic wack_in
);
  initial begin
    tgt_out = 7'h00;
    addr_out = 8'h00;
    rd_out = 1'b0;
    wr_out = 1'b0;
    wd_out = 8'h00;
  end
  // ==========================================================
  // Single byte accesses; released lines go inverse so stale values never match
  task automatic rd(input logic [6:0] t, input logic [7:0] a, output logic [7:0] d,
                    output logic k);
    @(posedge clk_in);
    #1;
    tgt_out = t;
    addr_out = a;
    rd_out = 1'b1;
    @(posedge clk_in);
    #1;
    rd_out = 1'b0;
    tgt_out = ~t;
    addr_out = ~a;
    d = rdata_in;
    k = rack_in;
  endtask
  task automatic wr(input logic [6:0] t, input logic [7:0] a, input logic [7:0] v,
                    output logic k);
    @(posedge clk_in);
    #1;
    tgt_out = t;
    addr_out = a;
    wd_out = (a == 8'h71) ? (v & 8'hc0) : v;
    wr_out = 1'b1;
    @(posedge clk_in);
    #1;
    wr_out = 1'b0;
    tgt_out = ~t;
    addr_out = ~a;
    wd_out = ~wd_out;
    k = wack_in;
  endtask
endmodule

`default_nettype wire

// *** test/diagnostic_alarm_flags_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none

module diagnostic_alarm_flags_tb_top;
  import daf_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  daf_byte_t res [5];
  daf_byte_t up [5];
  daf_byte_t lo [5];
  logic [4:0] st = 5'h00;
  logic [6:0] tgt;
  daf_byte_t addr, wd, rdata, p_out, r_out, e_p, e_r, d;
  logic rd, wr, rack, wack, k;
  int failures = 0;
  int samples_checked = 0;
  localparam daf_byte_t CR [6] = '{8'h81, 8'h80, 8'h0f, 8'h10, 8'hff, 8'h00};

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    foreach (res[i]) begin
      res[i] = 8'h00;
      up[i] = 8'hff;
      lo[i] = 8'h00;
    end
  end

  daf_top dut (.sys_clk_in(sys_clk), .rst_n_in(rst_n),
    .temperature_result_hi_in(res[0]), .temp_alarm_upper_hi_in(up[0]),
    .temp_alarm_lower_hi_in(lo[0]), .temperature_store_in(st[0]),
    .supply_result_hi_in(res[1]), .supply_alarm_upper_hi_in(up[1]),
    .supply_alarm_lower_hi_in(lo[1]), .supply_store_in(st[1]),
    .laser_current_result_hi_in(res[2]), .laser_current_alarm_upper_hi_in(up[2]),
    .laser_current_alarm_lower_hi_in(lo[2]), .laser_current_store_in(st[2]),
    .transmit_power_result_hi_in(res[3]), .transmit_power_alarm_upper_hi_in(up[3]),
    .transmit_power_alarm_lower_hi_in(lo[3]), .transmit_power_store_in(st[3]),
    .receive_power_result_hi_in(res[4]), .receive_power_alarm_upper_hi_in(up[4]),
    .receive_power_alarm_lower_hi_in(lo[4]), .receive_power_store_in(st[4]),
    .reg_target_in(tgt), .reg_addr_in(addr), .reg_rd_in(rd), .reg_wr_in(wr),
    .reg_wdata_in(wd), .reg_rdata_out(rdata), .reg_rd_ack_out(rack),
    .reg_wr_ack_out(wack), .alarm_flags_primary_out(p_out), .alarm_flags_receive_out(r_out));

  daf_host_model host (.clk_in(sys_clk), .tgt_out(tgt), .addr_out(addr), .rd_out(rd),
    .wr_out(wr), .wd_out(wd), .rdata_in(rdata), .rack_in(rack), .wack_in(wack));

  // ==========================================================
  // Compare and stimulus tasks
  task automatic chk8(input string n, input daf_byte_t e, input daf_byte_t g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic store(input int p, input daf_byte_t r);
    @(posedge sys_clk);
    #1;
    res[p] = r;
    up[p] = 8'h80;
    lo[p] = 8'h10;
    st[p] = 1'b1;
    @(posedge sys_clk);
    #1;
    st[p] = 1'b0;
    if (p < 4) begin
      e_p[7-2*p] = r > 8'h80;
      e_p[6-2*p] = r < 8'h10;
    end else begin
      e_r[7] = r > 8'h80;
      e_r[6] = r < 8'h10;
    end
  endtask
  task automatic check_both;
    host.rd(7'h51, 8'h70, d, k);
    chk1("rd_ack_primary", 1'b1, k);
    chk8("primary", e_p, d);
    chk8("primary_mirror", e_p, p_out);
    host.rd(7'h51, 8'h71, d, k);
    chk1("rd_ack_receive", 1'b1, k);
    chk8("receive", e_r, d);
    chk8("receive_mirror", e_r, r_out);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Tests; a watchdog covers a hung handshake
  initial begin
    #100000;
    failures++;
    $display("watchdog expired");
    tally_and_finish();
  end
  initial begin
    e_p = 8'h00;
    e_r = 8'h00;
    repeat (6) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    check_both();
    $display("test reset_values done");
    for (int p = 0; p < 5; p++) begin
      for (int c = 0; c < 6; c++) begin
        store(p, CR[c]);
        check_both();
      end
    end
    $display("test compare_table done");
    // Limit moves alone must not re-evaluate the latched low flag
    lo[0] = 8'h00;
    check_both();
    host.wr(7'h51, 8'h70, 8'hff, k);
    chk1("wr_ack_primary", 1'b1, k);
    host.wr(7'h51, 8'h71, 8'hff, k);
    chk1("wr_ack_receive", 1'b1, k);
    check_both();
    host.rd(7'h51, 8'h72, d, k);
    chk1("miss_addr_ack", 1'b0, k);
    chk8("miss_addr_rdata", e_r, d);
    host.rd(7'h50, 8'h70, d, k);
    chk1("miss_target_ack", 1'b0, k);
    host.wr(7'h51, 8'h6f, 8'h00, k);
    chk1("miss_wr_ack", 1'b0, k);
    $display("test access_decode done");
    @(posedge sys_clk);
    #1 rst_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    e_p = 8'h00;
    e_r = 8'h00;
    repeat (3) @(posedge sys_clk);
    check_both();
    $display("test second_reset done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
